// ### drive_comm_cfg.svh
// Purpose: offsets, field positions and reset values of the drive comm register area
// Assumes: one 16-bit word per address, word-addressed access port
// Notes: included by the register bank
// Functional notes
// [RULE1] status word: speed arrival 6, dc braking 7, stopping 8, brake open 10, 9 unused
// [RULE2] status word: fwd command 11, rev command 12, remote run 13, remote speed 14
// [RULE3] trip word: overcurrent one 0, bus high 1, ext fault 2, block 3, bus low 4
// [RULE4] trip word: ground fault 6, motor thermal 7, overload 8
// [RULE5] trip word: selftest 10, overcurrent two 12, addon 13, phase loss 14, inv overload 15
// [RULE6] input word mirrors eight digital inputs on bits 0 to 7, rest zero
// [RULE7] output word: relays on bits 0 to 3, fault relay bit 7, 4 to 6 zero
// [RULE8] command bit 0 rising issues a stop pulse
// [RULE9] command bit 1 rising issues a forward run pulse
// [RULE10] command bit 2 rising issues a reverse run pulse
// [RULE11] command bit 3 rising issues a fault reset pulse
// [RULE12] command bit 4 rising issues an emergency stop pulse
// [RULE13] only 0-to-1 edges act; a held bit does not repeat its action
// [RULE14] writes to read-only words are ignored and leave them unchanged
`ifndef DRIVE_COMM_CFG_SVH
`define DRIVE_COMM_CFG_SVH

`define ADDR_RUN_COMMAND 16'h0006
`define ADDR_DRIVE_STATUS 16'h000e
`define ADDR_TRIP_FLAGS 16'h000f
`define ADDR_DIN_STATE 16'h0010
`define ADDR_DOUT_STATE 16'h0011
`define ADDR_VOLT_IN_A 16'h0012
`define ADDR_VOLT_IN_B 16'h0013
`define ADDR_CURRENT_IN 16'h0014
`define ADDR_SHAFT_SPEED 16'h0015
`define ADDR_DISPLAY_UNIT 16'h001a
`define ADDR_POLE_COUNT 16'h001b
`define ADDR_CUSTOM_VERSION 16'h001c

`define CMD_STOP_BIT 0
`define CMD_FWD_BIT 1
`define CMD_REV_BIT 2
`define CMD_RESET_BIT 3
`define CMD_ESTOP_BIT 4
`define CMD_WRITABLE_MASK 16'h001f
`define RUN_COMMAND_RESET 16'h0000

`define ST_SPEED_ARRIVAL 6
`define ST_DC_BRAKING 7
`define ST_STOPPING 8
`define ST_BRAKE_OPEN 10
`define ST_FWD_CMD 11
`define ST_REV_CMD 12
`define ST_REMOTE_RUN 13
`define ST_REMOTE_SPEED 14

`define TRIP_USED_MASK 16'hf5df
`define DOUT_FAULT_RELAY_BIT 7
`define DIN_WIDTH 8
`define RELAY_WIDTH 4

`endif

// ### drive_comm_pkg.sv
// Purpose: types of the drive comm register area
// Assumes: nothing beyond the cfg header
// Notes: holds the state record of the bank
package drive_comm_pkg;
	typedef struct packed {
		logic [15:0] runCommand;
		logic [4:0] cmdPulse;
		logic [15:0] readData;
		logic readValid;
	} bank_state_t;
endpackage

// ### drive_comm_status_command_map.sv
// Purpose: serial-link register area of a motor drive, status words and run command
// Assumes: the link front end presents one decoded word access per strobe
// Notes: read data is valid one cycle after the read strobe
`timescale 1ns/1ps
`include "drive_comm_cfg.svh"

module drive_comm_status_command_map
	import drive_comm_pkg::*;
#(
	parameter int ADDR_WIDTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_WIDTH-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regWriteData,
	output logic [15:0] regReadData,
	output logic regReadValid,
	input wire logic speedArrival,
	input wire logic dcBraking,
	input wire logic stopping,
	input wire logic brakeOpen,
	input wire logic fwdRunCmd,
	input wire logic revRunCmd,
	input wire logic remote_runstop_source,
	input wire logic remote_speed_ref_source,
	input wire logic [5:0] driveStateLow,
	input wire logic [15:0] tripFlags,
	input wire logic [`DIN_WIDTH-1:0] multiInputs,
	input wire logic [`RELAY_WIDTH-1:0] relayOuts,
	input wire logic fault_relay,
	input wire logic [15:0] voltage_in_a,
	input wire logic [15:0] voltage_in_b,
	input wire logic [15:0] currentIn,
	input wire logic [15:0] shaftSpeed,
	input wire logic [15:0] displayUnit,
	input wire logic [15:0] poleCount,
	input wire logic [15:0] customVersion,
	output logic stopPulse,
	output logic fwdRunPulse,
	output logic revRunPulse,
	output logic faultResetPulse,
	output logic estopPulse
);

	// the highest mapped word needs five address bits
	if (ADDR_WIDTH < 5 || ADDR_WIDTH > 16) begin : g_bad_addr_width
		$error("ADDR_WIDTH must lie between 5 and 16");
	end

	bank_state_t state;
	bank_state_t next_state;
	logic [15:0] statusWord;
	logic [15:0] dinWord;
	logic [15:0] doutWord;
	logic [15:0] newCmd;
	logic [15:0] fullAddr;

	assign fullAddr = 16'(regAddr);

	// status word assembly
	always_comb begin
		statusWord = 16'h0000;
		statusWord[5:0] = driveStateLow;
		statusWord[`ST_SPEED_ARRIVAL] = speedArrival; // RULE1
		statusWord[`ST_DC_BRAKING] = dcBraking; // RULE1
		statusWord[`ST_STOPPING] = stopping; // RULE1
		statusWord[`ST_BRAKE_OPEN] = brakeOpen; // RULE1
		statusWord[`ST_FWD_CMD] = fwdRunCmd; // RULE2
		statusWord[`ST_REV_CMD] = revRunCmd; // RULE2
		statusWord[`ST_REMOTE_RUN] = remote_runstop_source; // RULE2
		statusWord[`ST_REMOTE_SPEED] = remote_speed_ref_source; // RULE2
	end

	// terminal words
	always_comb begin
		dinWord = 16'h0000;
		dinWord[`DIN_WIDTH-1:0] = multiInputs; // RULE6
		doutWord = 16'h0000;
		doutWord[`RELAY_WIDTH-1:0] = relayOuts; // RULE7
		doutWord[`DOUT_FAULT_RELAY_BIT] = fault_relay; // RULE7
	end

	always_comb begin
		next_state = state;
		next_state.cmdPulse = 5'h00;
		next_state.readValid = 1'b0;
		newCmd = regWriteData & `CMD_WRITABLE_MASK;
		// only the command word takes writes
		if (regWrite && fullAddr == `ADDR_RUN_COMMAND) begin // RULE14
			next_state.runCommand = newCmd;
			// rising edges only
			next_state.cmdPulse = newCmd[4:0] & ~state.runCommand[4:0]; // RULE8 RULE9 RULE10 RULE11 RULE12 RULE13
		end
		if (regRead) begin
			next_state.readValid = 1'b1;
			unique case (fullAddr)
				`ADDR_RUN_COMMAND: next_state.readData = state.runCommand;
				`ADDR_DRIVE_STATUS: next_state.readData = statusWord;
				`ADDR_TRIP_FLAGS: next_state.readData = tripFlags & `TRIP_USED_MASK; // RULE3 RULE4 RULE5
				`ADDR_DIN_STATE: next_state.readData = dinWord;
				`ADDR_DOUT_STATE: next_state.readData = doutWord;
				`ADDR_VOLT_IN_A: next_state.readData = voltage_in_a;
				`ADDR_VOLT_IN_B: next_state.readData = voltage_in_b;
				`ADDR_CURRENT_IN: next_state.readData = currentIn;
				`ADDR_SHAFT_SPEED: next_state.readData = shaftSpeed;
				`ADDR_DISPLAY_UNIT: next_state.readData = displayUnit;
				`ADDR_POLE_COUNT: next_state.readData = poleCount;
				`ADDR_CUSTOM_VERSION: next_state.readData = customVersion;
				default: next_state.readData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state.runCommand <= `RUN_COMMAND_RESET;
			state.cmdPulse <= 5'h00;
			state.readData <= 16'h0000;
			state.readValid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign regReadData = state.readData;
	assign regReadValid = state.readValid;
	assign stopPulse = state.cmdPulse[`CMD_STOP_BIT]; // RULE8
	assign fwdRunPulse = state.cmdPulse[`CMD_FWD_BIT]; // RULE9
	assign revRunPulse = state.cmdPulse[`CMD_REV_BIT]; // RULE10
	assign faultResetPulse = state.cmdPulse[`CMD_RESET_BIT]; // RULE11
	assign estopPulse = state.cmdPulse[`CMD_ESTOP_BIT]; // RULE12

	// checks
	logic cmdWr;
	assign cmdWr = regWrite && fullAddr == `ADDR_RUN_COMMAND;

	property p_rise(int b);
		@(posedge ref_clk) disable iff (!rst_n)
		(cmdWr && regWriteData[b] && !state.runCommand[b]) |=> state.cmdPulse[b];
	endproperty

	chk_stop_on_rise: assert property (p_rise(0)) else $error("stop pulse missing"); // RULE8
	chk_fwd_on_rise: assert property (p_rise(1)) else $error("forward pulse missing"); // RULE9
	chk_rev_on_rise: assert property (p_rise(2)) else $error("reverse pulse missing"); // RULE10
	chk_reset_on_rise: assert property (p_rise(3)) else $error("reset pulse missing"); // RULE11
	chk_estop_on_rise: assert property (p_rise(4)) else $error("estop pulse missing"); // RULE12
	chk_held_no_repeat: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cmdWr && regWriteData[1] && state.runCommand[1]) |=> !fwdRunPulse)
		else $error("held forward bit repeated"); // RULE13
	chk_pulse_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		stopPulse |=> (!stopPulse || $past(cmdWr)))
		else $error("stop pulse stretched"); // RULE13
	chk_ro_unchanged: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrite && !cmdWr) |=> ($stable(state.runCommand) && state.cmdPulse == 5'h00))
		else $error("read-only write had effect"); // RULE14
	chk_status_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DRIVE_STATUS) |=>
		(regReadData[`ST_FWD_CMD] == $past(fwdRunCmd) && regReadData[9] == 1'b0))
		else $error("status word wrong"); // RULE1 RULE2
	chk_trip_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_TRIP_FLAGS) |=>
		(regReadData[5] == 1'b0 && regReadData[11] == 1'b0 && regReadData[9] == 1'b0))
		else $error("trip reserved bit set"); // RULE3 RULE5
	chk_dout_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DOUT_STATE) |=>
		(regReadData[6:4] == 3'b000 && regReadData[7] == $past(fault_relay)))
		else $error("output word wrong"); // RULE7
	chk_din_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DIN_STATE) |=> regReadData == {8'h00, $past(multiInputs)})
		else $error("input word wrong"); // RULE6
	chk_status_low_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DRIVE_STATUS) |=>
		(regReadData[6] == $past(speedArrival) && regReadData[7] == $past(dcBraking) &&
		regReadData[8] == $past(stopping) && regReadData[10] == $past(brakeOpen)))
		else $error("status braking bits wrong"); // RULE1
	chk_status_remote: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DRIVE_STATUS) |=>
		(regReadData[12] == $past(revRunCmd) &&
		regReadData[13] == $past(remote_runstop_source) &&
		regReadData[14] == $past(remote_speed_ref_source)))
		else $error("status command bits wrong"); // RULE2
	chk_trip_low_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_TRIP_FLAGS) |=>
		regReadData[4:0] == $past(tripFlags[4:0]))
		else $error("trip low bits wrong"); // RULE3
	chk_trip_mid_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_TRIP_FLAGS) |=>
		regReadData[8:6] == $past(tripFlags[8:6]))
		else $error("trip middle bits wrong"); // RULE4
	chk_trip_high_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_TRIP_FLAGS) |=>
		(regReadData[10] == $past(tripFlags[10]) &&
		regReadData[15:12] == $past(tripFlags[15:12])))
		else $error("trip high bits wrong"); // RULE5
	chk_relay_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regRead && fullAddr == `ADDR_DOUT_STATE) |=>
		(regReadData[3:0] == $past(relayOuts) && regReadData[15:8] == 8'h00))
		else $error("relay bits wrong"); // RULE7
	chk_no_write_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cmdWr |=> state.cmdPulse == 5'h00)
		else $error("pulse without command write"); // RULE13
	chk_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
		regRead |=> regReadValid)
		else $error("read valid missing");
	chk_read_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!regRead |=> !regReadValid)
		else $error("read valid without read");

	cov_fwd_start: cover property (@(posedge ref_clk) disable iff (!rst_n) fwdRunPulse);
	cov_fault_reset: cover property (@(posedge ref_clk) disable iff (!rst_n) faultResetPulse);
	cov_estop: cover property (@(posedge ref_clk) disable iff (!rst_n) estopPulse);
	cov_read_trip: cover property (@(posedge ref_clk) disable iff (!rst_n)
		regRead && fullAddr == `ADDR_TRIP_FLAGS);

endmodule // drive_comm_status_command_map

// ### link_master_model.sv
// Purpose: remote serial master issuing word reads and writes
// Assumes: one decoded word access per strobe, read answer one cycle later
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps

module link_master_model (
	input wire logic ref_clk,
	output logic [15:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [15:0] regWriteData,
	input wire logic [15:0] regReadData,
	input wire logic regReadValid
);
	initial begin
		regAddr = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 16'h0000;
	end

	// command bits act on 0-to-1, so callers clear a bit before reissuing it
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		regWriteData <= ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		v = regReadValid;
		d = regReadData;
	endtask
endmodule // link_master_model

// ### tb_drive_comm_status_command_map.sv
// Purpose: self-checking bench of the drive comm register area
// Assumes: status inputs all follow one pattern word
// Notes: expected words are built from the pattern
`timescale 1ns/1ps

module tb_drive_comm_status_command_map;
	import drive_comm_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] pat = 16'ha5c3;
	logic [15:0] regAddr, regWriteData, regReadData, rdv;
	logic regWrite, regRead, regReadValid, ok;
	logic stopPulse, fwdRunPulse, revRunPulse, faultResetPulse, estopPulse;
	logic [15:0] pv;
	logic [15:0] addrs [12] = '{16'h000e, 16'h000f, 16'h0010, 16'h0011, 16'h0012, 16'h0013,
		16'h0014, 16'h0015, 16'h001a, 16'h001b, 16'h001c, 16'h0020};
	int n_mismatch = 0;
	int n_checks = 0;

	assign pv = {11'h000, estopPulse, faultResetPulse, revRunPulse, fwdRunPulse, stopPulse};

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	link_master_model mst (.ref_clk, .regAddr, .regWrite, .regRead, .regWriteData,
		.regReadData, .regReadValid);

	drive_comm_status_command_map dut_u (.ref_clk, .rst_n, .regAddr, .regWrite, .regRead,
		.regWriteData, .regReadData, .regReadValid, .speedArrival(pat[6]),
		.dcBraking(pat[7]), .stopping(pat[8]), .brakeOpen(pat[10]), .fwdRunCmd(pat[11]),
		.revRunCmd(pat[12]), .remote_runstop_source(pat[13]),
		.remote_speed_ref_source(pat[14]), .driveStateLow(pat[5:0]), .tripFlags(pat),
		.multiInputs(pat[7:0]), .relayOuts(pat[3:0]), .fault_relay(pat[7]),
		.voltage_in_a(pat), .voltage_in_b(~pat), .currentIn({pat[7:0], pat[15:8]}),
		.shaftSpeed(pat ^ 16'h0f0f), .displayUnit(pat ^ 16'h00ff),
		.poleCount(pat ^ 16'hff00), .customVersion(~{pat[7:0], pat[15:8]}), .stopPulse,
		.fwdRunPulse, .revRunPulse, .faultResetPulse, .estopPulse);

	function automatic logic [15:0] word_of(input logic [15:0] a, input logic [15:0] p);
		case (a)
			16'h000e: word_of = p & 16'h7dff;
			16'h000f: word_of = p & 16'hf5df;
			16'h0010: word_of = p & 16'h00ff;
			16'h0011: word_of = p & 16'h008f;
			16'h0012: word_of = p;
			16'h0013: word_of = ~p;
			16'h0014: word_of = {p[7:0], p[15:8]};
			16'h0015: word_of = p ^ 16'h0f0f;
			16'h001a: word_of = p ^ 16'h00ff;
			16'h001b: word_of = p ^ 16'hff00;
			16'h001c: word_of = ~{p[7:0], p[15:8]};
			default: word_of = 16'h0000;
		endcase
	endfunction

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
		mst.rd(a, rdv, ok);
		chk("read valid", 16'h0001, {15'h0000, ok});
		chk(n, e, rdv);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdchk("command reset", 16'h0006, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			mst.wr(16'h0006, 16'h0001 << i);
			#1 chk("command pulse", 16'h0001 << i, pv);
			mst.wr(16'h0006, 16'h0001 << i);
			#1 chk("held bit pulse", 16'h0000, pv);
			mst.wr(16'h0006, 16'h0000);
		end
		mst.wr(16'h0006, 16'hffff);
		#1 chk("all pulses", 16'h001f, pv);
		rdchk("command mask", 16'h0006, 16'h001f);
		mst.wr(16'h0006, 16'h0000);
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			pat <= p == 0 ? 16'ha5c3 : 16'h5a3c;
			@(posedge ref_clk);
			for (int j = 0; j < 12; j++) begin
				rdchk("status word", addrs[j], word_of(addrs[j], pat));
				mst.wr(addrs[j], 16'hffff);
				#1 chk("read-only write pulse", 16'h0000, pv);
				rdchk("read-only word kept", addrs[j], word_of(addrs[j], pat));
			end
		end
		rdchk("command kept", 16'h0006, 16'h0000);
		results;
	end
endmodule // tb_drive_comm_status_command_map
